/* bench/rtc_calendar_tb_top.sv */
// Self-checking bench for the calendar clock: bus master tasks, fast crystal, time model.
// Assumes rtc_pkg and rtl/rtc_calendar.sv are compiled first; one crystal tick per 4 CLK.
`timescale 1ns/100ps
module rtc_calendar_tb_top import rtc_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, bat_n = 1'b0, run = 1'b0, xtal = 1'b0, ce = 1'b1;
	logic rd = 1'b0, wr = 1'b0, waitreq, irq, ev;
	logic [5:0] addr = 6'h00;
	logic [31:0] wdata = 32'h0, rdata, q, seed = 32'hE49C;
	logic [6:0] trim;
	logic [1:0] xc = 2'h0;
	int bad_count = 0, total_checks = 0, cyc = 0, t0, d, m, y, s;
	int cy[6] = '{4, 4, 5, 5, 99, 7};
	int cm[6] = '{2, 2, 2, 12, 12, 4};
	int cd[6] = '{28, 29, 28, 31, 31, 30};
	int rp[4] = '{8, 8, 9, 9};
	int rf[4] = '{0, 1, 0, 3};

	rtc_calendar #(.FIRST_PERIOD(17'h00010)) dut (.CLK(clk), .RST_N(rst_n),
		.BATTERY_BACKED_SUPPLY_RST_N(bat_n), .CE(ce),
		.CRYSTAL_TICK(xtal), .ADDRESS(addr), .READ(rd), .WRITE(wr), .WRITEDATA(wdata),
		.READDATA(rdata), .WAITREQUEST(waitreq), .ONE_SECOND_IRQ(irq),
		.ONE_SECOND_EVENT(ev), .LOAD_CAP_TRIM(trim));

	always #10 clk = ~clk;

	// Crystal stands still while run is low, so no boundary lands mid-setup
	// Two cycles high, two low: the synchroniser needs both stages to agree
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (run) begin
			xc <= xc + 2'h1;
			xtal <= xc[1];
		end
		if (cyc == 20000) begin
			bad_count++;
			$display("CHECK FAILED at %0t: timeout", $time);
			tally_and_finish();
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic int dim(int yy, int mm);
		if (mm == 2) begin
			return (yy % 4 == 0) ? 29 : 28;
		end
		return (mm == 4 || mm == 6 || mm == 9 || mm == 11) ? 30 : 31;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string t);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, t, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Request held until the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
		int k;
		k = 0;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= v;
		do begin
			@(posedge clk);
			k++;
		end while (waitreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk(k, 2, "wait states");
	endtask

	task automatic rc(input logic [5:0] a, input logic [31:0] e, input string t);
		bus(1'b0, a, 32'h0);
		chk(q, e, t);
	endtask

	task automatic wt(input logic [5:0] a, input logic [31:0] v);
		bus(1'b1, ADDR_UNLOCK, xs());
		bus(1'b1, a, v);
	endtask

	task automatic wait_ev();
		do begin
			@(posedge clk);
		end while (ev !== 1'b1);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		bat_n <= 1'b1;
		chk(trim, TRIM_RST, "trim pin");
		rc(ADDR_TRIM, TRIM_RST, "trim");
		rc(ADDR_RATE, {PERIOD_RST, FRAC_RST}, "rate");
		rc(6'h34, 32'h0, "unmapped");
		rc(ADDR_SEC, 32'h0, "sec");
		rc(ADDR_DOW, 32'h1, "dow");
		rc(ADDR_MON, 32'h1, "mon");
		bus(1'b1, ADDR_RATE, 32'h20);
		run <= 1'b1;
		wait_ev();
		$display("test reset finished");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ADDR_RATE, 32'(rp[i] * 4 + rf[i]));
			rc(ADDR_RATE, 32'(rp[i] * 4 + rf[i]), "rate");
			wait_ev();
			t0 = cyc;
			repeat (8) wait_ev();
			chk(cyc - t0, 4 * (4 * rp[i] + rf[i]), "8 s length");
		end
		$display("test rate finished");
		for (int i = 0; i < 6; i++) begin
			run <= 1'b0;
			wt(ADDR_HOUR, 32'h17);
			wt(ADDR_MIN, 32'h3B);
			wt(ADDR_DOW, 32'h7);
			wt(ADDR_DOM, 32'(cd[i]));
			wt(ADDR_MON, 32'(cm[i]));
			wt(ADDR_YEAR, 32'(cy[i]));
			wt(ADDR_SEC, 32'h3B);
			run <= 1'b1;
			wait_ev();
			rc(ADDR_SEC, 32'h3B, "sec load");
			wait_ev();
			run <= 1'b0;
			d = cd[i] + 1;
			m = cm[i];
			y = cy[i];
			if (d > dim(y, m)) begin
				d = 1;
				m++;
			end
			if (m > 12) begin
				m = 1;
				y = (y + 1) % 100;
			end
			rc(ADDR_SEC, 32'h0, "sec");
			rc(ADDR_HOUR, 32'h0, "hour");
			rc(ADDR_DOW, 32'h1, "dow");
			rc(ADDR_DOM, 32'(d), "dom");
			rc(ADDR_MON, 32'(m), "mon");
			rc(ADDR_YEAR, 32'(y), "year");
		end
		$display("test calendar finished");
		bus(1'b1, ADDR_MIN, 32'h7);
		bus(1'b1, ADDR_UNLOCK, xs());
		bus(1'b1, ADDR_RESTART, xs());
		bus(1'b1, ADDR_MIN, 32'h8);
		rc(ADDR_SEC, 32'h0, "sec");
		rc(ADDR_MIN, 32'h0, "locked min");
		wt(ADDR_MIN, 32'h9);
		rc(ADDR_MIN, 32'h0, "stale min");
		rc(ADDR_SEC, 32'h0, "sec");
		rc(ADDR_MIN, 32'h9, "min");
		$display("test unlock finished");
		bus(1'b1, ADDR_IRQ, 32'h1);
		run <= 1'b1;
		wait_ev();
		run <= 1'b0;
		rc(ADDR_IRQ, 32'h3, "flag");
		chk(irq, 32'h1, "irq pin");
		bus(1'b1, ADDR_IRQ, 32'h3);
		rc(ADDR_IRQ, 32'h3, "flag kept");
		bus(1'b1, ADDR_IRQ, 32'h1);
		rc(ADDR_IRQ, 32'h1, "flag cleared");
		chk(irq, 32'h0, "irq pin");
		bus(1'b1, ADDR_RESTART, xs());
		rc(ADDR_FRACTION_OF_SECOND_COUNT, 32'hFF, "restart");
		run <= 1'b1;
		@(posedge xtal);
		run <= 1'b0;
		repeat (5) @(posedge clk);
		bus(1'b0, ADDR_FRACTION_OF_SECOND_COUNT, 32'h0);
		chk(32'(q < 32'hFF), 32'h1, "count down");
		$display("test event finished");
		for (int i = 0; i < 3; i++) begin
			s = (i == 0) ? 0 : (i == 1) ? 32'h3F : int'(xs() & 32'h7F);
			bus(1'b1, ADDR_TRIM, 32'(s));
			rc(ADDR_TRIM, 32'(s), "trim");
			chk(trim, 32'(s), "trim pin");
		end
		// Clock enable low: crystal edges must not advance the time
		ce <= 1'b0;
		run <= 1'b1;
		repeat (40) @(posedge clk);
		run <= 1'b0;
		ce <= 1'b1;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, ADDR_SEC, 32'h0);
		do begin
			s = int'(q);
			bus(1'b0, ADDR_SEC, 32'h0);
		end while (q !== 32'(s));
		rc(ADDR_SEC, 32'h1, "sec");
		rc(ADDR_MIN, 32'h9, "min");
		rc(ADDR_YEAR, 32'(y), "year");
		chk(trim, TRIM_RST, "trim pin");
		$display("test keep finished");
		tally_and_finish();
	end
endmodule // rtc_calendar_tb_top

/* include/rtc_pkg.sv */
// Register map, field layout and reset values of the calendar clock.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package rtc_pkg;
	localparam logic [5:0] ADDR_SEC = 6'h00;
	localparam logic [5:0] ADDR_MIN = 6'h04;
	localparam logic [5:0] ADDR_HOUR = 6'h08;
	localparam logic [5:0] ADDR_DOW = 6'h0C;
	localparam logic [5:0] ADDR_DOM = 6'h10;
	localparam logic [5:0] ADDR_MON = 6'h14;
	localparam logic [5:0] ADDR_YEAR = 6'h18;
	localparam logic [5:0] ADDR_UNLOCK = 6'h1C;
	localparam logic [5:0] ADDR_TRIM = 6'h20;
	localparam logic [5:0] ADDR_RATE = 6'h24;
	localparam logic [5:0] ADDR_FRACTION_OF_SECOND_COUNT = 6'h28;
	localparam logic [5:0] ADDR_RESTART = 6'h2C;
	localparam logic [5:0] ADDR_IRQ = 6'h30;
	localparam int RATE_FRAC_LSB = 0;
	localparam int RATE_PER_LSB = 2;
	localparam int IRQ_EN_BIT = 0;
	localparam int IRQ_FLAG_BIT = 1;
	localparam logic [16:0] PERIOD_RST = 17'h10000;
	localparam logic [1:0] FRAC_RST = 2'h0;
	localparam logic [6:0] TRIM_RST = 7'h20;
	localparam logic [7:0] SUB_TOP = 8'hFF;
	localparam logic [17:0] SUB_STEP = 18'h00100;
	localparam logic [5:0] SEC_MAX = 6'h3B;
	localparam logic [5:0] MIN_MAX = 6'h3B;
	localparam logic [4:0] HOUR_MAX = 5'h17;
	localparam logic [2:0] DOW_MAX = 3'h7;
	localparam logic [3:0] MON_MAX = 4'hC;
	localparam logic [6:0] YEAR_MAX = 7'h63;
	typedef struct packed {
		logic [6:0] yr;
		logic [3:0] mon;
		logic [4:0] dom;
		logic [2:0] dow;
		logic [4:0] hr;
		logic [5:0] mn;
		logic [5:0] sc;
	} rtc_time_s;
	localparam rtc_time_s TIME_RST = '{yr: 7'h00, mon: 4'h1, dom: 5'h01, dow: 3'h1,
		hr: 5'h00, mn: 6'h00, sc: 6'h00};
endpackage

/* rtl/rtc_calendar.sv */
// Calendar clock with trim, rate adjust, sub-second count and one-second event.
// Assumes CRYSTAL_TICK is the raw 32.768 kHz square wave, asynchronous to CLK.
//
// Notes on behaviour
// - Seconds to year counters; minutes to year read through snapshot registers, seconds read live.
// - Day of month rolls over by month length, February leap-aware.
// - Time counters reset only by the battery supply reset; outputs reset by the system reset.
// - Reading seconds snapshots all other time output registers together.
// - Every read takes exactly one wait state.
// - A time register write is accepted only right after an unlock write.
// - New rate values load into the counters at the next second boundary.
// - Period and fraction are contiguous; 4*period+fraction cycles per 8 s.
// - Reset period is 0x10000 and fraction 0, giving 32768 cycles per second.
// - Fraction LSB adds single cycles through a carry accumulator.
// - Seven-bit load trim drives the oscillator, changeable at any time.
// - Sub-second count holds remaining 1/256 second units until the boundary.
// - Any write to the restart register restarts the sub-second count.
// - Seconds write loads at the next boundary instead of the increment.
// - Counters advance only on crystal edges, never on the system clock rate.
// - One-second flag has an enable and drives the shared interrupt request.
// - Flag cleared only by writing zero to it; ones are ignored.
`timescale 1ns/100ps
module rtc_calendar import rtc_pkg::*; #(
	// Period used until the first boundary after a battery reset
	parameter logic [16:0] FIRST_PERIOD = PERIOD_RST
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic BATTERY_BACKED_SUPPLY_RST_N,
	input wire logic CE,
	input wire logic CRYSTAL_TICK,
	input wire logic [5:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	output logic ONE_SECOND_IRQ,
	output logic ONE_SECOND_EVENT,
	output logic [6:0] LOAD_CAP_TRIM
);
	function automatic logic [4:0] days_in_month(input logic [3:0] m, input logic [6:0] y);
		case (m)
			4'h2: days_in_month = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB: days_in_month = 5'h1E;
			default: days_in_month = 5'h1F;
		endcase
	endfunction

	logic [2:0] xs_reg;
	logic xl_reg;
	logic [16:0] cyc_reg;
	logic [2:0] facc_reg;
	logic extra_reg;
	logic [16:0] per_act_reg;
	logic [1:0] frac_act_reg;
	rtc_time_s t_reg, t_next, snap_reg;
	logic [5:0] pend_reg;
	logic pend_v_reg;
	logic [7:0] sub_reg;
	logic [16:0] sacc_reg;
	logic wait_reg, unlock_reg, flag_reg, en_reg, irq_reg, evt_reg;
	logic [16:0] per_sw_reg;
	logic [1:0] frac_sw_reg;
	logic [6:0] trim_reg;
	logic [31:0] rdata_reg, rd_w;

	// Crystal edge, counted once stages two and three agree
	wire xstable_w = xs_reg[1] == xs_reg[2];
	wire tick_w = CE && xstable_w && xs_reg[2] && !xl_reg;
	wire [16:0] seclen_w = {1'b0, per_act_reg[16:1]} + {16'h0000, extra_reg};
	wire sec_tick_w = tick_w && (cyc_reg == seclen_w - 17'h00001);
	wire [3:0] fsum_w = {1'b0, facc_reg} + {1'b0, per_sw_reg[0], frac_sw_reg};
	wire [17:0] ssum_w = {1'b0, sacc_reg} + SUB_STEP;
	wire sstep_w = ssum_w >= {1'b0, seclen_w};

	// Bus handshake
	wire req_w = CE && (READ || WRITE) && wait_reg;
	wire done_w = CE && (READ || WRITE) && !wait_reg;
	wire wr_w = done_w && WRITE;
	wire rd_sec_w = req_w && READ && ADDRESS == ADDR_SEC;
	wire time_addr_w = ADDRESS <= ADDR_YEAR && ADDRESS[1:0] == 2'h0;
	wire wr_time_w = wr_w && unlock_reg && time_addr_w;
	wire wr_restart_w = wr_w && ADDRESS == ADDR_RESTART;
	wire wr_irq_w = wr_w && ADDRESS == ADDR_IRQ;
	wire flag_clr_w = wr_irq_w && !WRITEDATA[IRQ_FLAG_BIT];
	wire [4:0] dim_w = days_in_month(t_reg.mon, t_reg.yr);

	always_comb begin
		t_next = t_reg;
		if (sec_tick_w) begin
			if (pend_v_reg) begin
				t_next.sc = pend_reg;
			end else if (t_reg.sc < SEC_MAX) begin
				t_next.sc = t_reg.sc + 6'h01;
			end else begin
				t_next.sc = 6'h00;
				t_next.mn = (t_reg.mn < MIN_MAX) ? t_reg.mn + 6'h01 : 6'h00;
				if (t_reg.mn == MIN_MAX) begin
					t_next.hr = (t_reg.hr < HOUR_MAX) ? t_reg.hr + 5'h01 : 5'h00;
					if (t_reg.hr == HOUR_MAX) begin
						t_next.dow = (t_reg.dow < DOW_MAX) ? t_reg.dow + 3'h1 : 3'h1;
						t_next.dom = (t_reg.dom < dim_w) ? t_reg.dom + 5'h01 : 5'h01;
						if (t_reg.dom >= dim_w) begin
							t_next.mon = (t_reg.mon < MON_MAX) ? t_reg.mon + 4'h1 : 4'h1;
							if (t_reg.mon == MON_MAX) begin
								t_next.yr = (t_reg.yr < YEAR_MAX) ? t_reg.yr + 7'h01 : 7'h00;
							end
						end
					end
				end
			end
		end
		if (wr_time_w) begin
			case (ADDRESS)
				ADDR_MIN: t_next.mn = WRITEDATA[5:0];
				ADDR_HOUR: t_next.hr = WRITEDATA[4:0];
				ADDR_DOW: t_next.dow = WRITEDATA[2:0];
				ADDR_DOM: t_next.dom = WRITEDATA[4:0];
				ADDR_MON: t_next.mon = WRITEDATA[3:0];
				ADDR_YEAR: t_next.yr = WRITEDATA[6:0];
				default: t_next.sc = t_next.sc;
			endcase
		end
	end

	always_comb begin
		rd_w = 32'h00000000;
		case (ADDRESS)
			ADDR_SEC: rd_w[5:0] = t_reg.sc;
			ADDR_MIN: rd_w[5:0] = snap_reg.mn;
			ADDR_HOUR: rd_w[4:0] = snap_reg.hr;
			ADDR_DOW: rd_w[2:0] = snap_reg.dow;
			ADDR_DOM: rd_w[4:0] = snap_reg.dom;
			ADDR_MON: rd_w[3:0] = snap_reg.mon;
			ADDR_YEAR: rd_w[6:0] = snap_reg.yr;
			ADDR_TRIM: rd_w[6:0] = trim_reg;
			ADDR_RATE: rd_w[18:0] = {per_sw_reg, frac_sw_reg};
			ADDR_FRACTION_OF_SECOND_COUNT: rd_w[7:0] = sub_reg;
			ADDR_IRQ: rd_w[1:0] = {flag_reg, en_reg};
			default: rd_w = 32'h00000000;
		endcase
	end

	// Battery-backed domain: survives the system reset
	always_ff @(posedge CLK or negedge BATTERY_BACKED_SUPPLY_RST_N) begin
		if (!BATTERY_BACKED_SUPPLY_RST_N) begin
			xs_reg <= 3'h0;
			xl_reg <= 1'b0;
			cyc_reg <= 17'h00000;
			facc_reg <= 3'h0;
			extra_reg <= 1'b0;
			per_act_reg <= FIRST_PERIOD;
			frac_act_reg <= FRAC_RST;
			t_reg <= TIME_RST;
			snap_reg <= TIME_RST;
			pend_reg <= 6'h00;
			pend_v_reg <= 1'b0;
			sub_reg <= SUB_TOP;
			sacc_reg <= 17'h00000;
		end else if (CE) begin
			xs_reg <= {xs_reg[1:0], CRYSTAL_TICK};
			if (xstable_w) begin
				xl_reg <= xs_reg[2];
			end
			t_reg <= t_next;
			if (rd_sec_w) begin
				snap_reg <= t_reg;
			end
			if (wr_time_w && ADDRESS == ADDR_SEC) begin
				pend_reg <= WRITEDATA[5:0];
				pend_v_reg <= 1'b1;
			end else if (sec_tick_w) begin
				pend_v_reg <= 1'b0;
			end
			if (sec_tick_w) begin
				cyc_reg <= 17'h00000;
				per_act_reg <= per_sw_reg;
				frac_act_reg <= frac_sw_reg;
				facc_reg <= fsum_w[2:0];
				extra_reg <= fsum_w[3];
			end else if (tick_w) begin
				cyc_reg <= cyc_reg + 17'h00001;
			end
			if (sec_tick_w || wr_restart_w) begin
				sub_reg <= SUB_TOP;
				sacc_reg <= 17'h00000;
			end else if (tick_w) begin
				sacc_reg <= sstep_w ? 17'(ssum_w - {1'b0, seclen_w}) : ssum_w[16:0];
				if (sstep_w && sub_reg != 8'h00) begin
					sub_reg <= sub_reg - 8'h01;
				end
			end
		end
	end

	// System domain: bus slave and control
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
			unlock_reg <= 1'b0;
			flag_reg <= 1'b0;
			en_reg <= 1'b0;
			irq_reg <= 1'b0;
			evt_reg <= 1'b0;
			per_sw_reg <= PERIOD_RST;
			frac_sw_reg <= FRAC_RST;
			trim_reg <= TRIM_RST;
		end else if (CE) begin
			if (req_w) begin
				wait_reg <= 1'b0;
				rdata_reg <= rd_w;
			end else if (done_w) begin
				wait_reg <= 1'b1;
			end
			if (wr_w) begin
				unlock_reg <= ADDRESS == ADDR_UNLOCK;
			end
			if (wr_w && ADDRESS == ADDR_TRIM) begin
				trim_reg <= WRITEDATA[6:0];
			end
			if (wr_w && ADDRESS == ADDR_RATE) begin
				per_sw_reg <= WRITEDATA[RATE_PER_LSB +: 17];
				frac_sw_reg <= WRITEDATA[RATE_FRAC_LSB +: 2];
			end
			if (wr_irq_w) begin
				en_reg <= WRITEDATA[IRQ_EN_BIT];
			end
			flag_reg <= sec_tick_w || (flag_reg && !flag_clr_w);
			irq_reg <= flag_reg && en_reg;
			evt_reg <= sec_tick_w;
		end
	end

	assign READDATA = rdata_reg;
	assign WAITREQUEST = wait_reg;
	assign ONE_SECOND_IRQ = irq_reg;
	assign ONE_SECOND_EVENT = evt_reg;
	assign LOAD_CAP_TRIM = trim_reg;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N || !BATTERY_BACKED_SUPPLY_RST_N);

	sequence s_read_req;
		CE && READ && wait_reg;
	endsequence
	sequence s_read_done;
		!wait_reg ##1 wait_reg;
	endsequence
	property p_read_wait;
		s_read_req |=> s_read_done;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read not one wait state");
	property p_snapshot;
		rd_sec_w |=> snap_reg == $past(t_reg);
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");
	property p_locked;
		(wr_w && !unlock_reg && ADDRESS == ADDR_MIN && !sec_tick_w) |=> $stable(t_reg.mn);
	endproperty
	a_locked: assert property (p_locked) else $error("locked write changed minutes");
	property p_sec_load;
		(sec_tick_w && pend_v_reg && !(wr_time_w && ADDRESS == ADDR_SEC)) |=>
			t_reg.sc == $past(pend_reg) && !pend_v_reg;
	endproperty
	a_sec_load: assert property (p_sec_load) else $error("pending seconds not loaded");
	property p_flag_set;
		sec_tick_w |=> (flag_reg && ONE_SECOND_EVENT) ##1 !ONE_SECOND_EVENT;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set at boundary");
	property p_flag_ones;
		(CE && flag_reg && wr_irq_w && WRITEDATA[IRQ_FLAG_BIT]) |=> flag_reg;
	endproperty
	a_flag_ones: assert property (p_flag_ones) else $error("writing one cleared flag");
	property p_irq;
		(CE && flag_reg && en_reg) |=> ONE_SECOND_IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("enabled flag gave no request");
	property p_restart;
		wr_restart_w |=> sub_reg == SUB_TOP && sacc_reg == 17'h00000;
	endproperty
	a_restart: assert property (p_restart) else $error("sub-second not restarted");
	property p_rate_load;
		sec_tick_w |=> per_act_reg == $past(per_sw_reg) && frac_act_reg == $past(frac_sw_reg);
	endproperty
	a_rate_load: assert property (p_rate_load) else $error("rate not loaded at boundary");
	property p_dom_range;
		t_reg.dom >= 5'h01 && t_reg.dom <= days_in_month(t_reg.mon, t_reg.yr);
	endproperty
	a_dom_range: assert property (p_dom_range) else $error("day of month out of range");
	property p_write_wait;
		(CE && WRITE && wait_reg) |=> s_read_done;
	endproperty
	a_write_wait: assert property (p_write_wait) else $error("write not one wait state");
	property p_flag_clear;
		(flag_clr_w && !sec_tick_w) |=> !flag_reg;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("zero write kept flag");
	property p_evt_pulse;
		ONE_SECOND_EVENT |=> !ONE_SECOND_EVENT;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than one cycle");
endmodule // rtc_calendar
